// ---- logic/adcthr_regs.sv ----
/*
 adcthr_regs: byte-addressed register set of the ADC post-processing computation:
 accumulator, setpoint, error, lower and upper thresholds, control and interrupt.
 assumes: register port strobes are one cycle and never both high; sample_valid_i
 marks a finished conversion with sample_i and prev_i stable in that cycle.
*/
// Design decision made here: the plain strobed port.
// What this block does
// (RULE1) accumulator is 18-bit signed, read/write by software, undefined at reset
// (RULE2) software accumulator writes only take effect while no conversion runs
// (RULE3) accumulator bytes: upper holds bits 17:16, high 15:8, low 7:0
// (RULE4) setpoint is 16-bit signed read/write, cleared at reset
// (RULE5) error follows calculation mode; setpoint used only where the mode needs it
// (RULE6) setpoint error is 16-bit signed and read-only, undefined at reset
// (RULE7) setpoint error reads as high byte 15:8 and low byte 7:0
// (RULE8) lower threshold is 16-bit signed read/write, cleared at reset
// (RULE9) upper threshold is 16-bit signed read/write, cleared at reset
// (RULE10) setpoint and thresholds reach software as separate high and low bytes
// (RULE11) error compared with both thresholds updates the above and below flags
// (RULE12) threshold interrupt raised only as the threshold mode selects
// (RULE13) signed compare: above when error exceeds upper, below when under lower
`timescale 1ns/1ps
module adcthr_regs #(
    parameter int DATA_W = adcthr_pkg::DATA_W,
    parameter int ACC_W  = adcthr_pkg::ACC_W
) (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        ce_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [7:0]  rdata_o,
    input  wire logic        conv_busy_i,
    input  wire logic        sample_valid_i,
    input  wire logic [15:0] sample_i,
    input  wire logic [15:0] prev_i,
    output logic             irq_o,
    output logic             above_upper_flag_o,
    output logic             below_lower_flag_o
);
    if (DATA_W != 16 || ACC_W < 17 || ACC_W > 24) begin : g_bad_width
        $error("adcthr_regs: DATA_W must be 16 and ACC_W 17..24");
    end

    function automatic logic [15:0] put_byte(input logic [15:0] old, input logic hi, input logic [7:0] d);
        put_byte = hi ? {d, old[7:0]} : {old[15:8], d};
    endfunction

    adcthr_cmp_if cmp ();

    logic [15:0]      llim_r;
    logic [15:0]      ulim_r;
    logic [15:0]      setp_r;
    logic [ACC_W-1:0] acc_r;
    logic [7:0]       ctrl_r;
    logic [7:0]       sts_r;
    logic [7:0]       ien_r;
    logic [7:0]       rdata_r;
    logic             irq_r;
    logic             above_r;
    logic             below_r;

    logic             wr_llim_lo, wr_llim_hi, wr_ulim_lo, wr_ulim_hi, wr_setp_lo, wr_setp_hi;
    logic             wr_acc_lo, wr_acc_hi, wr_acc_up, acc_wr_ok;
    logic             wr_ctrl, wr_clr, wr_ien;
    logic [15:0]      llim_nxt, ulim_nxt, setp_nxt;
    logic [ACC_W-1:0] acc_sum, acc_sw, acc_nxt;
    logic [7:0]       ctrl_nxt, ien_nxt, sts_set, sts_clr, sts_nxt, sts_view;
    logic [23:0]      acc_view;
    logic [7:0]       rd_mux;

    assign wr_llim_lo = wr_i & (addr_i == adcthr_pkg::LLIM_LO);
    assign wr_llim_hi = wr_i & (addr_i == adcthr_pkg::LLIM_HI);
    assign wr_ulim_lo = wr_i & (addr_i == adcthr_pkg::ULIM_LO);
    assign wr_ulim_hi = wr_i & (addr_i == adcthr_pkg::ULIM_HI);
    assign wr_setp_lo = wr_i & (addr_i == adcthr_pkg::SETP_LO);
    assign wr_setp_hi = wr_i & (addr_i == adcthr_pkg::SETP_HI);
    assign wr_acc_lo  = wr_i & (addr_i == adcthr_pkg::ACC_LO);
    assign wr_acc_hi  = wr_i & (addr_i == adcthr_pkg::ACC_HI);
    assign wr_acc_up  = wr_i & (addr_i == adcthr_pkg::ACC_UP);
    assign wr_ctrl    = wr_i & (addr_i == adcthr_pkg::CTRL);
    assign wr_clr     = wr_i & (addr_i == adcthr_pkg::ICLR);
    assign wr_ien     = wr_i & (addr_i == adcthr_pkg::IEN);
    assign acc_wr_ok  = !conv_busy_i; // RULE2

    // the error has no write decode at all, so software cannot disturb it
    assign llim_nxt = (wr_llim_lo | wr_llim_hi) ? put_byte(llim_r, wr_llim_hi, wdata_i) : llim_r; // RULE8 RULE10
    assign ulim_nxt = (wr_ulim_lo | wr_ulim_hi) ? put_byte(ulim_r, wr_ulim_hi, wdata_i) : ulim_r; // RULE9 RULE10
    assign setp_nxt = (wr_setp_lo | wr_setp_hi) ? put_byte(setp_r, wr_setp_hi, wdata_i) : setp_r; // RULE4 RULE10

    assign acc_sum = acc_r + {{(ACC_W-16){sample_i[15]}}, sample_i};
    assign acc_sw  = wr_acc_lo ? {acc_r[ACC_W-1:8], wdata_i} :
                     wr_acc_hi ? {acc_r[ACC_W-1:16], wdata_i, acc_r[7:0]} :
                     wr_acc_up ? {wdata_i[ACC_W-17:0], acc_r[15:0]} : acc_r; // RULE3
    // a finished conversion wins over a software write in the same cycle
    assign acc_nxt = sample_valid_i ? acc_sum : (acc_wr_ok ? acc_sw : acc_r); // RULE1 RULE2

    assign ctrl_nxt = wr_ctrl ? wdata_i : ctrl_r;
    assign ien_nxt  = wr_ien ? (wdata_i & adcthr_pkg::EV_MASK) : ien_r;
    assign sts_set  = {6'h00, cmp.done, cmp.hit};
    assign sts_clr  = wr_clr ? (wdata_i & adcthr_pkg::EV_MASK) : 8'h00;
    // an event in the cycle of its clear keeps the bit set
    assign sts_nxt  = (sts_r & ~sts_clr) | sts_set;

    assign sts_view = sts_r | {2'b00, below_r, above_r, 4'h0};
    // size cast, not a replication: a zero-width fill is illegal at ACC_W of 24
    assign acc_view = 24'(acc_r);

    assign rd_mux = (addr_i == adcthr_pkg::LLIM_LO) ? llim_r[7:0] :
                    (addr_i == adcthr_pkg::LLIM_HI) ? llim_r[15:8] :
                    (addr_i == adcthr_pkg::ULIM_LO) ? ulim_r[7:0] :
                    (addr_i == adcthr_pkg::ULIM_HI) ? ulim_r[15:8] :
                    (addr_i == adcthr_pkg::ERR_LO)  ? cmp.err[7:0] : // RULE7
                    (addr_i == adcthr_pkg::ERR_HI)  ? cmp.err[15:8] : // RULE7
                    (addr_i == adcthr_pkg::SETP_LO) ? setp_r[7:0] :
                    (addr_i == adcthr_pkg::SETP_HI) ? setp_r[15:8] :
                    (addr_i == adcthr_pkg::ACC_LO)  ? acc_view[7:0] : // RULE3
                    (addr_i == adcthr_pkg::ACC_HI)  ? acc_view[15:8] :
                    (addr_i == adcthr_pkg::ACC_UP)  ? acc_view[23:16] :
                    (addr_i == adcthr_pkg::CTRL)    ? ctrl_r :
                    (addr_i == adcthr_pkg::STAT)    ? sts_view :
                    (addr_i == adcthr_pkg::IEN)     ? ien_r : 8'h00;

    assign cmp.start     = sample_valid_i;
    assign cmp.calculation_mode_mode = ctrl_r[adcthr_pkg::CALCULATION_MODE_LSB +: adcthr_pkg::MODE_W]; // RULE5
    assign cmp.thm       = ctrl_r[adcthr_pkg::THM_LSB +: adcthr_pkg::MODE_W]; // RULE12
    assign cmp.setpoint  = setp_r;
    assign cmp.llim      = llim_r; // RULE11
    assign cmp.ulim      = ulim_r; // RULE11
    assign cmp.sample    = sample_i;
    assign cmp.prev      = prev_i;

    adcthr_calculation_mode u_calculation_mode (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .cmp       (cmp.unit)
    );

    // accumulator has no defined reset value; cleared only to keep x out of reads
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            acc_r <= '0;
        end else if (ce_i) begin
            acc_r <= acc_nxt; // RULE1
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            llim_r <= adcthr_pkg::THR_RST; // RULE8
            ulim_r <= adcthr_pkg::THR_RST; // RULE9
            setp_r <= adcthr_pkg::THR_RST; // RULE4
            ctrl_r <= adcthr_pkg::CTRL_RST;
            ien_r  <= adcthr_pkg::IEN_RST;
        end else if (ce_i) begin
            llim_r <= llim_nxt;
            ulim_r <= ulim_nxt;
            setp_r <= setp_nxt;
            ctrl_r <= ctrl_nxt;
            ien_r  <= ien_nxt;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sts_r   <= 8'h00;
            irq_r   <= 1'b0;
            rdata_r <= 8'h00;
            above_r <= 1'b0;
            below_r <= 1'b0;
        end else if (ce_i) begin
            sts_r   <= sts_nxt;
            irq_r   <= |(sts_nxt & ien_nxt); // RULE12
            rdata_r <= rd_i ? rd_mux : 8'h00;
            above_r <= cmp.above; // RULE11
            below_r <= cmp.below; // RULE11
        end
    end

    assign rdata_o            = rdata_r;
    assign irq_o              = irq_r;
    assign above_upper_flag_o = cmp.above;
    assign below_lower_flag_o = cmp.below;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_acc_lo_write;
        wr_acc_lo && ce_i && !sample_valid_i;
    endsequence

    chk_acc_write_idle: assert property ((s_acc_lo_write and !conv_busy_i)
        |=> acc_r[7:0] == $past(wdata_i)) else $error("idle accumulator write lost"); // RULE1
    chk_acc_write_busy: assert property ((s_acc_lo_write and conv_busy_i)
        |=> $stable(acc_r)) else $error("accumulator written during conversion"); // RULE2
    chk_acc_upper_read: assert property ((rd_i && ce_i && addr_i == adcthr_pkg::ACC_UP)
        |=> rdata_o == $past(acc_view[23:16])) else $error("accumulator upper byte wrong"); // RULE3
    chk_setp_hi_write: assert property ((wr_setp_hi && ce_i)
        |=> setp_r[15:8] == $past(wdata_i) && $stable(setp_r[7:0])) else $error("setpoint high byte"); // RULE4
    chk_err_read_only: assert property ((wr_i && ce_i && addr_i == adcthr_pkg::ERR_HI && !sample_valid_i)
        |=> $stable(cmp.err)) else $error("error register was written"); // RULE6
    chk_err_hi_read: assert property ((rd_i && ce_i && addr_i == adcthr_pkg::ERR_HI)
        |=> rdata_o == $past(cmp.err[15:8])) else $error("error high byte read"); // RULE7
    chk_llim_lo_write: assert property ((wr_llim_lo && ce_i)
        |=> llim_r == {$past(llim_r[15:8]), $past(wdata_i)}) else $error("lower threshold low byte"); // RULE8
    chk_ulim_hi_read: assert property ((rd_i && ce_i && addr_i == adcthr_pkg::ULIM_HI)
        |=> rdata_o == $past(ulim_r[15:8])) else $error("upper threshold high byte read"); // RULE9
    chk_setp_lo_read: assert property ((rd_i && ce_i && addr_i == adcthr_pkg::SETP_LO)
        |=> rdata_o == $past(setp_r[7:0])) else $error("setpoint low byte read"); // RULE10
    chk_flag_follow: assert property ((sample_valid_i && ce_i) ##1 ce_i
        |=> above_r == $past(cmp.above) && below_r == $past(cmp.below)) else $error("status flags lag"); // RULE11
    chk_irq_level: assert property ((cmp.hit && ce_i && ien_nxt[adcthr_pkg::ST_HIT])
        |=> irq_o && sts_r[adcthr_pkg::ST_HIT]) else $error("threshold interrupt missing"); // RULE12
endmodule // adcthr_regs

// ---- logic/adcthr_pkg.sv ----
/*
 adcthr_pkg: addresses, field positions, reset values and mode encodings of the
 setpoint / threshold computation register set.
 assumes: byte-wide register port, one register byte per address.
*/
package adcthr_pkg;

    localparam int          ADDR_W     = 16;
    localparam int          DATA_W     = 16;
    localparam int          ACC_W      = 18;

    localparam logic [15:0] LLIM_LO    = 16'h1d0c;
    localparam logic [15:0] LLIM_HI    = 16'h1d0d;
    localparam logic [15:0] ULIM_LO    = 16'h1d0e;
    localparam logic [15:0] ULIM_HI    = 16'h1d0f;
    localparam logic [15:0] ERR_LO     = 16'h1d10;
    localparam logic [15:0] ERR_HI     = 16'h1d11;
    localparam logic [15:0] SETP_LO    = 16'h1d12;
    localparam logic [15:0] SETP_HI    = 16'h1d13;
    localparam logic [15:0] ACC_LO     = 16'h1d16;
    localparam logic [15:0] ACC_HI     = 16'h1d17;
    localparam logic [15:0] ACC_UP     = 16'h1d18;
    localparam logic [15:0] CTRL       = 16'h1d40;
    localparam logic [15:0] STAT       = 16'h1d41;
    localparam logic [15:0] ICLR       = 16'h1d42;
    localparam logic [15:0] IEN        = 16'h1d43;

    localparam int          CALCULATION_MODE_LSB   = 0;
    localparam int          THM_LSB    = 4;
    localparam int          MODE_W     = 3;
    localparam int          ST_HIT     = 0;
    localparam int          ST_DONE    = 1;
    localparam int          ST_ABOVE   = 4;
    localparam int          ST_BELOW   = 5;
    localparam logic [7:0]  EV_MASK    = 8'h03;

    localparam logic [7:0]  CTRL_RST   = 8'h00;
    localparam logic [7:0]  IEN_RST    = 8'h00;
    localparam logic [15:0] THR_RST    = 16'h0000;

    typedef enum logic [2:0] {
        CALCULATION_MODE_DELTA_PREV,
        CALCULATION_MODE_FROM_SETPOINT,
        CALCULATION_MODE_PREV_SETPOINT,
        CALCULATION_MODE_RAW
    } adcthr_calculation_mode_e;

    typedef enum logic [2:0] {
        THM_NEVER,
        THM_BELOW,
        THM_NOT_BELOW,
        THM_OUTSIDE,
        THM_INSIDE,
        THM_NOT_ABOVE,
        THM_ABOVE,
        THM_ALWAYS
    } adcthr_thm_e;

endpackage

// ---- logic/adcthr_cmp_if.sv ----
/*
 adcthr_cmp_if: operands and results between the register set and the compute unit.
 assumes: one clock; start is a one-cycle pulse qualified by the clock enable.
*/
`timescale 1ns/1ps
interface adcthr_cmp_if;
    logic               start;
    logic [2:0]         calculation_mode_mode;
    logic [2:0]         thm;
    logic signed [15:0] setpoint;
    logic signed [15:0] llim;
    logic signed [15:0] ulim;
    logic signed [15:0] sample;
    logic signed [15:0] prev;
    logic signed [15:0] err;
    logic               above;
    logic               below;
    logic               hit;
    logic               done;

    modport ctl (output start, calculation_mode_mode, thm, setpoint, llim, ulim, sample, prev,
                 input  err, above, below, hit, done);
    modport unit (input  start, calculation_mode_mode, thm, setpoint, llim, ulim, sample, prev,
                  output err, above, below, hit, done);
endinterface

// ---- logic/adcthr_calculation_mode.sv ----
/*
 adcthr_calculation_mode: setpoint error computation and signed threshold comparison.
 assumes: operands stable in the cycle of the start pulse.
*/
`timescale 1ns/1ps
module adcthr_calculation_mode (
    input  wire logic  clk_i,
    input  wire logic  sys_rst_i,
    input  wire logic  ce_i,
    adcthr_cmp_if.unit cmp
);
    // saturate rather than wrap, so a wild sample cannot flip the sign of the error
    function automatic logic signed [15:0] sat_sub(input logic signed [15:0] a, input logic signed [15:0] b);
        logic signed [16:0] d;
        d = {a[15], a} - {b[15], b};
        if (d[16] != d[15]) begin
            sat_sub = d[16] ? 16'sh8000 : 16'sh7fff;
        end else begin
            sat_sub = d[15:0];
        end
    endfunction

    logic signed [15:0] err_r;
    logic signed [15:0] err_nxt;
    logic               above_r;
    logic               below_r;
    logic               hit_r;
    logic               done_r;
    logic               above_nxt;
    logic               below_nxt;
    logic               hit_nxt;

    always_comb begin
        unique case (adcthr_pkg::adcthr_calculation_mode_e'(cmp.calculation_mode_mode))
            adcthr_pkg::CALCULATION_MODE_DELTA_PREV:    err_nxt = sat_sub(cmp.sample, cmp.prev); // RULE5
            adcthr_pkg::CALCULATION_MODE_FROM_SETPOINT: err_nxt = sat_sub(cmp.sample, cmp.setpoint); // RULE5
            adcthr_pkg::CALCULATION_MODE_PREV_SETPOINT: err_nxt = sat_sub(cmp.prev, cmp.setpoint); // RULE5
            default:                        err_nxt = cmp.sample;
        endcase
    end

    assign above_nxt = err_nxt > cmp.ulim; // RULE13
    assign below_nxt = err_nxt < cmp.llim; // RULE13

    always_comb begin
        unique case (adcthr_pkg::adcthr_thm_e'(cmp.thm))
            adcthr_pkg::THM_NEVER:     hit_nxt = 1'b0; // RULE12
            adcthr_pkg::THM_BELOW:     hit_nxt = below_nxt;
            adcthr_pkg::THM_NOT_BELOW: hit_nxt = !below_nxt;
            adcthr_pkg::THM_OUTSIDE:   hit_nxt = below_nxt | above_nxt;
            adcthr_pkg::THM_INSIDE:    hit_nxt = !below_nxt & !above_nxt;
            adcthr_pkg::THM_NOT_ABOVE: hit_nxt = !above_nxt;
            adcthr_pkg::THM_ABOVE:     hit_nxt = above_nxt;
            adcthr_pkg::THM_ALWAYS:    hit_nxt = 1'b1;
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            err_r   <= '0;
            above_r <= 1'b0;
            below_r <= 1'b0;
            hit_r   <= 1'b0;
            done_r  <= 1'b0;
        end else if (ce_i) begin
            hit_r  <= cmp.start & hit_nxt; // RULE12
            done_r <= cmp.start;
            if (cmp.start) begin
                err_r   <= err_nxt; // RULE6
                above_r <= above_nxt; // RULE11
                below_r <= below_nxt; // RULE11
            end
        end
    end

    assign cmp.err   = err_r;
    assign cmp.above = above_r;
    assign cmp.below = below_r;
    assign cmp.hit   = hit_r;
    assign cmp.done  = done_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    chk_setpoint_error: assert property ((cmp.start && ce_i && cmp.calculation_mode_mode == 3'h1)
        |=> cmp.err == sat_sub($past(cmp.sample), $past(cmp.setpoint))) else $error("error not sample minus setpoint"); // RULE5
    chk_upper_compare: assert property ((cmp.start && ce_i)
        |=> cmp.above == (cmp.err > $past(cmp.ulim))) else $error("upper flag wrong"); // RULE13
    chk_lower_compare: assert property ((cmp.start && ce_i)
        |=> cmp.below == (cmp.err < $past(cmp.llim))) else $error("lower flag wrong"); // RULE11
    chk_never_mode: assert property ((cmp.start && ce_i && cmp.thm == 3'h0) |=> !cmp.hit)
        else $error("hit in never mode"); // RULE12
endmodule // adcthr_calculation_mode

// ---- tb/adcthr_tb.sv ----
/*
 tb: self-checking bench of adcthr_regs with an integer model of registers, error, flags and interrupt.
 assumes: byte register port with read data one cycle after the strobe; ce_i held high except for the one frozen-write check.
*/
`timescale 1ns/1ps
module tb;
    logic        clk_i          = 1'b0;
    logic        sys_rst_i      = 1'b1;
    logic        ce_i           = 1'b1;
    logic [15:0] addr_i         = 16'h0000;
    logic [7:0]  wdata_i        = 8'h00;
    logic        wr_i           = 1'b0;
    logic        rd_i           = 1'b0;
    logic        conv_busy_i    = 1'b0;
    logic        sample_valid_i = 1'b0;
    logic [15:0] sample_i       = 16'h0000;
    logic [15:0] prev_i         = 16'h0000;
    wire  [7:0]  rdata_o;
    wire         irq_o;
    wire         above_upper_flag_o;
    wire         below_lower_flag_o;
    int          n_mismatch     = 0;
    int          samples_checked = 0;
    logic [31:0] seed           = 32'hcefa;
    logic [15:0] m_llim, m_ulim, m_setp, m_err;
    logic [17:0] m_acc;
    logic [7:0]  m_ctrl;
    logic [1:0]  m_ien, m_stat;
    logic        m_above, m_below;

    always #12.5 clk_i = ~clk_i;

    adcthr_regs i_dut (
        .clk_i              (clk_i),
        .sys_rst_i          (sys_rst_i),
        .ce_i               (ce_i),
        .addr_i             (addr_i),
        .wdata_i            (wdata_i),
        .wr_i               (wr_i),
        .rd_i               (rd_i),
        .rdata_o            (rdata_o),
        .conv_busy_i        (conv_busy_i),
        .sample_valid_i     (sample_valid_i),
        .sample_i           (sample_i),
        .prev_i             (prev_i),
        .irq_o              (irq_o),
        .above_upper_flag_o (above_upper_flag_o),
        .below_lower_flag_o (below_lower_flag_o)
    );

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    task automatic give_verdict;
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe, so it is taken there
    task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1;
        check(what, exp, rdata_o);
    endtask

    task automatic wr16(input logic [15:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a + 16'h0001, v[15:8]);
    endtask

    task automatic rd16(input logic [15:0] a, input logic [15:0] v, input string what);
        rd(a, v[7:0], what);
        rd(a + 16'h0001, v[15:8], what);
    endtask

    task automatic sample(input logic [15:0] s, input logic [15:0] p);
        int   d;
        logic hit;
        m_acc = m_acc + {{2{s[15]}}, s};
        case (m_ctrl[2:0])
            3'h0: d = $signed(s) - $signed(p);
            3'h1: d = $signed(s) - $signed(m_setp);
            3'h2: d = $signed(p) - $signed(m_setp);
            default: d = $signed(s);
        endcase
        if (d > 32767) d = 32767;
        if (d < -32768) d = -32768;
        m_err   = d[15:0];
        m_above = $signed(m_err) > $signed(m_ulim);
        m_below = $signed(m_err) < $signed(m_llim);
        case (m_ctrl[6:4])
            3'h0: hit = 1'b0;
            3'h1: hit = m_below;
            3'h2: hit = !m_below;
            3'h3: hit = m_below || m_above;
            3'h4: hit = !m_below && !m_above;
            3'h5: hit = !m_above;
            3'h6: hit = m_above;
            default: hit = 1'b1;
        endcase
        m_stat = m_stat | {1'b1, hit};
        @(posedge clk_i);
        sample_i       <= s;
        prev_i         <= p;
        sample_valid_i <= 1'b1;
        @(posedge clk_i);
        sample_valid_i <= 1'b0;
        #1;
        check("above flag", {7'h00, m_above}, {7'h00, above_upper_flag_o});
        check("below flag", {7'h00, m_below}, {7'h00, below_lower_flag_o});
        @(posedge clk_i);
        #1;
        check("irq", {7'h00, |(m_stat & m_ien)}, {7'h00, irq_o});
    endtask

    // hang guard: far beyond the roughly 700 cycles the sequence needs
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        give_verdict();
    end

    initial begin
        logic [15:0] s, p;
        logic [2:0]  calculation_mode;
        {m_llim, m_ulim, m_setp, m_err, m_acc, m_ctrl, m_ien, m_stat} = '0;
        repeat (8) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd16(adcthr_pkg::LLIM_LO, 16'h0000, "lower threshold");
        rd16(adcthr_pkg::ULIM_LO, 16'h0000, "upper threshold");
        rd16(adcthr_pkg::SETP_LO, 16'h0000, "setpoint");
        seed = xs(seed);
        m_llim = seed[15:0];
        m_ulim = seed[31:16];
        seed = xs(seed);
        m_setp = seed[15:0];
        wr16(adcthr_pkg::LLIM_LO, m_llim);
        wr16(adcthr_pkg::ULIM_LO, m_ulim);
        wr16(adcthr_pkg::SETP_LO, m_setp);
        rd16(adcthr_pkg::LLIM_LO, m_llim, "lower threshold");
        rd16(adcthr_pkg::ULIM_LO, m_ulim, "upper threshold");
        rd16(adcthr_pkg::SETP_LO, m_setp, "setpoint");
        wr16(adcthr_pkg::ERR_LO, 16'h5aa5);
        rd16(adcthr_pkg::ERR_LO, m_err, "error after write");
        rd(16'h1d14, 8'h00, "unmapped read");
        seed = xs(seed);
        m_acc = {2'b11, seed[15:0]};
        wr(adcthr_pkg::ACC_LO, m_acc[7:0]);
        wr(adcthr_pkg::ACC_HI, m_acc[15:8]);
        wr(adcthr_pkg::ACC_UP, 8'hff);
        rd(adcthr_pkg::ACC_UP, {6'h00, m_acc[17:16]}, "acc upper");
        // a conversion in flight must lock the accumulator against software
        @(posedge clk_i);
        conv_busy_i <= 1'b1;
        wr(adcthr_pkg::ACC_LO, ~m_acc[7:0]);
        conv_busy_i <= 1'b0;
        rd(adcthr_pkg::ACC_LO, m_acc[7:0], "acc low while busy");
        // clock enable low must freeze the register set against a strobe
        ce_i <= 1'b0;
        wr(adcthr_pkg::LLIM_LO, ~m_llim[7:0]);
        ce_i <= 1'b1;
        rd16(adcthr_pkg::LLIM_LO, m_llim, "lower threshold frozen");
        m_llim = 16'hff9c;
        m_ulim = 16'h0064;
        m_setp = 16'h0030;
        wr16(adcthr_pkg::LLIM_LO, m_llim);
        wr16(adcthr_pkg::ULIM_LO, m_ulim);
        wr16(adcthr_pkg::SETP_LO, m_setp);
        for (int i = 0; i < 40; i++) begin
            seed = xs(seed);
            s    = {{7{seed[8]}}, seed[8:0]};
            p    = {{7{seed[24]}}, seed[24:16]};
            calculation_mode = (i % 5 == 4) ? 3'h7 : 3'(i % 5);
            // boundary cases first: exactly on each threshold, one past it, and both saturation ends
            case (i)
                0: {calculation_mode, s} = {3'h3, 16'h0064};
                1: {calculation_mode, s} = {3'h3, 16'hff9c};
                2: {calculation_mode, s} = {3'h3, 16'h0065};
                3: {calculation_mode, s} = {3'h3, 16'hff9b};
                4: {calculation_mode, s, p} = {3'h0, 16'h7fff, 16'h8000};
                5: {calculation_mode, s, p} = {3'h0, 16'h8000, 16'h7fff};
                default: ;
            endcase
            m_ctrl = {1'b0, 3'(i % 8), 1'b0, calculation_mode};
            m_ien  = seed[31:30];
            wr(adcthr_pkg::CTRL, m_ctrl);
            wr(adcthr_pkg::IEN, {6'h00, m_ien});
            wr(adcthr_pkg::ICLR, 8'h03);
            m_stat = 2'b00;
            sample(s, p);
            rd16(adcthr_pkg::ERR_LO, m_err, "setpoint error");
            rd(adcthr_pkg::STAT, {2'b00, m_below, m_above, 2'b00, m_stat}, "status");
        end
        rd(adcthr_pkg::ACC_LO, m_acc[7:0], "acc low");
        rd(adcthr_pkg::ACC_HI, m_acc[15:8], "acc high");
        rd(adcthr_pkg::ACC_UP, {6'h00, m_acc[17:16]}, "acc upper");
        give_verdict();
    end
endmodule // tb
